// File: design/ssm_consts.vh
// Constants for the safety supply monitor.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone bus.
`ifndef SSM_CONSTS_VH
`define SSM_CONSTS_VH
`define SSM_CLK_HZ      25000000
`define SSM_WD_MS       100
`define SSM_WD_CYCLES   ((`SSM_CLK_HZ / 1000) * `SSM_WD_MS)
`define SSM_ADR_CTRL    8'h00
`define SSM_ADR_WDOG    8'h04
`define SSM_ADR_STAT    8'h08
`define SSM_ADR_CKCTL   8'h0C
`define SSM_ADR_CKDAT   8'h10
`define SSM_ADR_CKVAL   8'h14
`define SSM_CTRL_CLAMP  0
`define SSM_CTRL_RELEN  1
`define SSM_CTRL_ERR    2
`define SSM_CTRL_RELSW  3
`define SSM_CTRL_RST    4'h0
`define SSM_ST_UV       0
`define SSM_ST_MEM      1
`define SSM_ST_TEMP     2
`define SSM_ST_PWR      3
`define SSM_ST_VBR      4
`define SSM_ST_CYC      5
`define SSM_ST_WD       6
`define SSM_ST_DLREF    7
`define SSM_ST_ULABT    8
`define SSM_ST_RCHK     9
`define SSM_ST_IGN      16
`define SSM_ST_TLOW     17
`define SSM_ST_TPIN     18
`define SSM_ST_RED      19
`define SSM_ST_STATE    20
`define SSM_OP_NONE     2'h0
`define SSM_OP_DL       2'h1
`define SSM_OP_UL       2'h2
`define SSM_OP_RCHK     2'h3
`endif

// File: design/ssm_supply_monitor.v
// Safety supply monitor: latching, monitoring relay, supply and watchdog
// resets, self-test sequencing, write protection and image checksums.
// Assumes comparator outputs and test results arrive as asynchronous pins.
`timescale 1ns/1ps
`include "ssm_consts.vh"
module ssm_supply_monitor #(
  parameter WD_CYCLES = `SSM_WD_CYCLES
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Supply comparators, asynchronous
  input  wire        batt_present_i,
  input  wire        ign_above8_i,
  input  wire        term_above8_i,
  input  wire        supply_above10_i,
  input  wire        test_pin_i,
  // Self-test engine, asynchronous
  input  wire        test_done_i,
  input  wire [5:0]  test_fail_i,
  // Cyclic monitors, asynchronous
  input  wire        overtemp_i,
  input  wire        power_fault_i,
  input  wire        relayed_fault_i,
  input  wire        io_fault_i,
  input  wire        coproc_alive_i,
  input  wire        xtal_ok_i,
  input  wire [2:0]  check_fail_i,
  // Power and relays
  output wire        power_keep_o,
  output wire        clamp_relay_o,
  output wire        relay_chan_a_o,
  output wire        relay_chan_b_o,
  output wire        outputs_en_o,
  // Sequencing
  output reg         test_start_o,
  output reg         sys_reset_o,
  output wire        io_diag_en_o,
  output wire        red_led_o,
  // Protection
  output wire        wp_sysdata_o,
  output wire        wp_flash_o,
  output wire        debug_en_o
);
  localparam S_INIT  = 3'h0;
  localparam S_TEST  = 3'h1;
  localparam S_RUN   = 3'h2;
  localparam S_STOP  = 3'h3;
  localparam S_FATAL = 3'h4;
  localparam S_UV    = 3'h5;
  localparam S_UVHLD = 3'h6;
  localparam NS = 15;

  // Two-flop synchronisers for every pin
  wire [NS-1:0] pins_raw;
  reg  [NS-1:0] meta_reg;
  reg  [NS-1:0] sync_reg;
  assign pins_raw = {check_fail_i, xtal_ok_i, coproc_alive_i, io_fault_i,
                     relayed_fault_i, power_fault_i, overtemp_i, test_done_i,
                     test_pin_i, supply_above10_i, term_above8_i,
                     ign_above8_i, batt_present_i};
  always @(posedge clk_i) begin
    meta_reg <= pins_raw;
    sync_reg <= meta_reg;
  end
  wire       batt_ok  = sync_reg[0];
  wire       ign_ok   = sync_reg[1];
  wire       term_ok  = sync_reg[2];
  wire       sup10_ok = sync_reg[3];
  wire       tpin     = sync_reg[4];
  wire       tdone    = sync_reg[5];
  wire       f_temp   = sync_reg[6];
  wire       f_pwr    = sync_reg[7];
  wire       f_vbr    = sync_reg[8];
  wire       f_io     = sync_reg[9];
  wire       cop_ok   = sync_reg[10];
  wire       xtal_ok  = sync_reg[11];
  wire [2:0] chk_fail = sync_reg[14:12];
  // Test results are captured only once done is seen, so a plain sync is enough
  reg  [5:0] tf_meta_reg;
  reg  [5:0] tf_reg;
  always @(posedge clk_i) begin
    tf_meta_reg <= test_fail_i;
    tf_reg      <= tf_meta_reg;
  end

  // Bus access
  wire bus_req = cyc_i & stb_i;
  wire wr_en   = bus_req & we_i & ack_o & sel_i[0];
  function hit;
    input [7:0] a;
    input [7:0] b;
    hit = (a == b);
  endfunction

  reg  [2:0]  state_reg;
  reg  [3:0]  ctrl_reg;
  reg  [9:0]  stat_reg;
  reg  [21:0] wd_cnt_reg;
  reg         red_reg;
  reg  [1:0]  ck_op_reg;
  reg         ck_eep_reg;
  reg  [15:0] ck_sum_reg;
  reg  [15:0] ck_store_reg;
  reg  [7:0]  ck_b1_reg;
  reg  [7:0]  ck_b2_reg;
  reg  [1:0]  ck_cnt_reg;
  reg         ck_ok_reg;

  wire kick      = wr_en & hit(adr_i, `SSM_ADR_WDOG);
  wire wd_expire = (wd_cnt_reg == WD_CYCLES[21:0] - 22'h1);
  wire running   = (state_reg == S_RUN);
  wire sys_fault = ~cop_ok | ~xtal_ok | (|chk_fail);
  wire io_bad    = f_io & running;
  wire cyc_fault = running & (sys_fault | io_bad | f_temp | f_pwr | f_vbr);
  wire mem_fail  = tf_reg[0] | tf_reg[3] | tf_reg[4] | tf_reg[5];
  wire oth_fail  = tf_reg[1] | tf_reg[2];

  // watchdog count; kicks ignored in undervoltage
  always @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt_reg <= 22'h000000;
    end else if ((state_reg != S_RUN) && (state_reg != S_STOP) && (state_reg != S_UV)) begin
      wd_cnt_reg <= 22'h000000;
    end else if (kick && (state_reg != S_UV)) begin
      wd_cnt_reg <= 22'h000000;
    end else if (!wd_expire) begin
      wd_cnt_reg <= wd_cnt_reg + 22'h000001;
    end
  end

  // Sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= S_INIT;
      test_start_o <= 1'b0;
      sys_reset_o  <= 1'b0;
      red_reg      <= 1'b0;
    end else begin
      test_start_o <= 1'b0;
      sys_reset_o  <= 1'b0;
      case (state_reg)
        S_INIT: begin
          red_reg <= 1'b0;
          if (ign_ok && sup10_ok) begin
            state_reg    <= S_TEST;
            test_start_o <= 1'b1;
          end
        end
        S_TEST: begin
          if (tdone && !test_start_o) begin
            if (oth_fail || (mem_fail && !tpin)) begin
              red_reg   <= 1'b1;
              state_reg <= S_FATAL;
            end else begin
              state_reg <= S_RUN;
            end
          end
        end
        S_RUN: begin
          if (!ign_ok) begin
            state_reg <= S_UV;
          end else if (wd_expire) begin
            sys_reset_o <= 1'b1;
            state_reg   <= S_INIT;
          end else if (cyc_fault) begin
            red_reg   <= 1'b1;
            state_reg <= S_STOP;
          end
        end
        S_STOP: begin
          if (!ign_ok) begin
            state_reg <= S_UV;
          end
        end
        S_UV: begin
          if (wd_expire) begin
            sys_reset_o <= 1'b1;
            state_reg   <= S_UVHLD;
          end
        end
        S_UVHLD: begin
          sys_reset_o <= 1'b1;
          if (ign_ok && term_ok && sup10_ok) begin
            state_reg <= S_INIT;
          end
        end
        S_FATAL: begin
          red_reg <= 1'b1;
        end
        default: begin
          state_reg <= S_INIT;
        end
      endcase
    end
  end

  // Control register; reset also on watchdog or undervoltage reset
  always @(posedge clk_i) begin
    if (rst_i || sys_reset_o) begin
      ctrl_reg <= `SSM_CTRL_RST;
    end else if (wr_en && hit(adr_i, `SSM_ADR_CTRL)) begin
      ctrl_reg <= dat_i[3:0];
      if (dat_i[`SSM_CTRL_ERR]) begin
        ctrl_reg[`SSM_CTRL_RELEN] <= 1'b0;
      end
    end
  end

  wire clamp_hold = ctrl_reg[`SSM_CTRL_CLAMP];
  wire rel_en     = ctrl_reg[`SSM_CTRL_RELEN];
  wire err_flag   = ctrl_reg[`SSM_CTRL_ERR];
  wire rel_sw     = ctrl_reg[`SSM_CTRL_RELSW];
  wire wd_healthy = running & ~wd_expire;

  wire latched = batt_ok & clamp_hold;
  assign power_keep_o  = ign_ok | latched;
  assign clamp_relay_o = clamp_hold;
  assign relay_chan_a_o = wd_healthy & rel_en & rel_sw;
  assign relay_chan_b_o = ~err_flag;
  assign outputs_en_o   = running & rel_en & ~err_flag;
  assign io_diag_en_o   = running;
  assign red_led_o      = red_reg;
  assign wp_sysdata_o = ~tpin;
  assign wp_flash_o   = ~tpin;
  assign debug_en_o   = tpin;

  // Checksum engine: the two newest bytes are held back as the checksum
  wire ck_ctl_wr = wr_en && hit(adr_i, `SSM_ADR_CKCTL);
  wire ck_dat_wr = wr_en && hit(adr_i, `SSM_ADR_CKDAT);
  wire ck_end    = ck_ctl_wr && dat_i[3] && (ck_op_reg != `SSM_OP_NONE);
  wire [15:0] ck_tail  = {ck_b2_reg, ck_b1_reg};
  wire        ck_match = (ck_cnt_reg == 2'h2) && (ck_tail == ck_sum_reg);
  wire        rc_match = (ck_sum_reg == ck_store_reg);
  reg  [9:0]  ev_set;
  always @* begin
    ev_set = 10'h000;
    ev_set[`SSM_ST_UV]   = (state_reg == S_RUN || state_reg == S_STOP) && !ign_ok;
    ev_set[`SSM_ST_MEM]  = (state_reg == S_TEST) && tdone && !test_start_o && mem_fail && tpin;
    ev_set[`SSM_ST_TEMP] = running & f_temp;
    ev_set[`SSM_ST_PWR]  = running & f_pwr;
    ev_set[`SSM_ST_VBR]  = running & f_vbr;
    ev_set[`SSM_ST_CYC]  = cyc_fault;
    ev_set[`SSM_ST_WD]   = running & ign_ok & wd_expire;
    ev_set[`SSM_ST_DLREF] = ck_end && (ck_op_reg == `SSM_OP_DL) && !ck_match;
    ev_set[`SSM_ST_ULABT] = ck_end && (ck_op_reg == `SSM_OP_UL) && !ck_match;
    ev_set[`SSM_ST_RCHK]  = ck_end && (ck_op_reg == `SSM_OP_RCHK) && !rc_match && !ck_eep_reg;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ck_op_reg    <= `SSM_OP_NONE;
      ck_eep_reg   <= 1'b0;
      ck_sum_reg   <= 16'h0000;
      ck_store_reg <= 16'h0000;
      ck_b1_reg    <= 8'h00;
      ck_b2_reg    <= 8'h00;
      ck_cnt_reg   <= 2'h0;
      ck_ok_reg    <= 1'b0;
    end else if (ck_end) begin
      ck_op_reg <= `SSM_OP_NONE;
      if (ck_op_reg == `SSM_OP_RCHK) begin
        ck_ok_reg <= rc_match | ck_eep_reg;
      end else begin
        ck_ok_reg <= ck_match;
      end
      if ((ck_op_reg == `SSM_OP_DL) && ck_match) begin
        ck_store_reg <= ck_sum_reg;
      end
    end else if (ck_ctl_wr && (dat_i[1:0] != `SSM_OP_NONE)) begin
      // Start clears the running sum, the byte count and the result flag
      ck_op_reg  <= dat_i[1:0];
      ck_eep_reg <= dat_i[2];
      ck_sum_reg <= 16'h0000;
      ck_cnt_reg <= 2'h0;
      ck_ok_reg  <= 1'b0;
    end else if (ck_dat_wr && (ck_op_reg != `SSM_OP_NONE)) begin
      ck_b2_reg <= ck_b1_reg;
      ck_b1_reg <= dat_i[7:0];
      if (ck_cnt_reg == 2'h2) begin
        ck_sum_reg <= ck_sum_reg + {8'h00, ck_b2_reg};
      end else begin
        ck_cnt_reg <= ck_cnt_reg + 2'h1;
      end
    end
  end

  // Sticky status; a set in the clearing cycle wins
  wire [9:0] st_clr = (wr_en && hit(adr_i, `SSM_ADR_STAT)) ? dat_i[9:0] : 10'h000;
  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= 10'h000;
    end else begin
      stat_reg <= (stat_reg & ~st_clr) | ev_set;
    end
  end

  // Read mux and ack; unmapped addresses read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req & ~ack_o;
      dat_o <= 32'h00000000;
      if (bus_req && !ack_o && !we_i) begin
        case (adr_i)
          `SSM_ADR_CTRL: dat_o <= {28'h0000000, ctrl_reg};
          `SSM_ADR_STAT: begin
            dat_o[9:0]           <= stat_reg;
            dat_o[`SSM_ST_IGN]   <= ign_ok;
            dat_o[`SSM_ST_TLOW]  <= ~term_ok;
            dat_o[`SSM_ST_TPIN]  <= tpin;
            dat_o[`SSM_ST_RED]   <= red_reg;
            dat_o[22:20]         <= state_reg;
          end
          `SSM_ADR_CKCTL: dat_o <= {26'h0, ck_ok_reg, (ck_op_reg != `SSM_OP_NONE),
                                    1'b0, ck_eep_reg, ck_op_reg};
          `SSM_ADR_CKVAL: dat_o <= {16'h0000, ck_sum_reg};
          default:        dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // ssm_supply_monitor

// File: verification/ssm_supply_monitor_asserts.sv
// Port checker for the safety supply monitor.
// Assumes the bind below; reset is synchronous and active high.
`timescale 1ns/1ps
`include "ssm_consts.vh"
module ssm_supply_monitor_asserts #(
  parameter WD_CYCLES = `SSM_WD_CYCLES
) (
  // Clock, reset and bus
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  // Pins
  input wire        batt_present_i,
  input wire        ign_above8_i,
  input wire        test_pin_i,
  // Outputs watched
  input wire        power_keep_o,
  input wire        clamp_relay_o,
  input wire        relay_chan_a_o,
  input wire        relay_chan_b_o,
  input wire        outputs_en_o,
  input wire        sys_reset_o,
  input wire        io_diag_en_o,
  input wire        red_led_o,
  input wire        wp_sysdata_o,
  input wire        wp_flash_o,
  input wire        debug_en_o
);
  wire ctrl_wr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == `SSM_ADR_CTRL;
  wire kick    = cyc_i && stb_i && we_i && ack_o && adr_i == `SSM_ADR_WDOG;
  int  wd_cnt;

  // Counter instead of a long delay range, which would be slow to unroll
  always @(posedge clk_i)
    if (rst_i || kick || !io_diag_en_o) wd_cnt <= 0;
    else wd_cnt <= wd_cnt + 1;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wb_req; cyc_i && stb_i && !ack_o; endsequence
  sequence err_wr; ctrl_wr && dat_i[`SSM_CTRL_ERR]; endsequence
  sequence ign_lost; !ign_above8_i [*4]; endsequence

  wb_ack_a: assert property (wb_req |=> ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  latch_hold_a: assert property (batt_present_i [*4] ##0 clamp_relay_o |-> power_keep_o)
    else $error("latching lost with clamp hold set");
  latch_drop_a: assert property (ign_lost ##0 !clamp_relay_o |-> !power_keep_o)
    else $error("power kept without ignition or clamp");
  err_open_a: assert property (err_wr |=> !relay_chan_b_o && !relay_chan_a_o && !outputs_en_o)
    else $error("error flag did not open relay");
  chan_gate_a: assert property (relay_chan_a_o |-> relay_chan_b_o && outputs_en_o && io_diag_en_o)
    else $error("channel a on without its enables");
  sw_drive_a: assert property (ctrl_wr && !dat_i[`SSM_CTRL_RELSW] |=> !relay_chan_a_o)
    else $error("relay stayed on against software state");
  wd_clear_a: assert property ($rose(sys_reset_o) |=> !relay_chan_a_o && !clamp_relay_o && !outputs_en_o)
    else $error("restart did not clear control");
  uv_stop_a: assert property (!ign_above8_i [*6] |-> !io_diag_en_o)
    else $error("still running under undervoltage");
  wp_on_a: assert property (!test_pin_i [*4] |-> wp_sysdata_o && wp_flash_o && !debug_en_o)
    else $error("protection off without test pin");
  wp_off_a: assert property (test_pin_i [*4] |-> !wp_sysdata_o && !wp_flash_o && debug_en_o)
    else $error("protection on with test pin");
  red_stop_a: assert property (red_led_o |-> !io_diag_en_o)
    else $error("red indicator while running");
  wd_bound_a: assert property (wd_cnt <= WD_CYCLES + 4)
    else $error("run outlived watchdog time");
endmodule // ssm_supply_monitor_asserts

bind ssm_supply_monitor ssm_supply_monitor_asserts #(.WD_CYCLES(WD_CYCLES)) i_chk (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .batt_present_i, .ign_above8_i, .test_pin_i, .power_keep_o,
  .clamp_relay_o, .relay_chan_a_o, .relay_chan_b_o, .outputs_en_o, .sys_reset_o, .io_diag_en_o, .red_led_o,
  .wp_sysdata_o, .wp_flash_o, .debug_en_o);

// File: verification/ssm_supply_monitor_test.sv
// Self-checking bench for the safety supply monitor.
// Assumes a shortened watchdog count and a 25 MHz clock.
`timescale 1ns/1ps
`include "ssm_consts.vh"
module ssm_supply_monitor_test;
  localparam WD = 300;
  reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, test_done_i = 0, test_pin_i = 0;
  reg batt_present_i = 1, ign_above8_i = 1, term_above8_i = 1, supply_above10_i = 1;
  reg overtemp_i = 0, power_fault_i = 0, relayed_fault_i = 0, io_fault_i = 0, coproc_alive_i = 1, xtal_ok_i = 1;
  reg [7:0]  adr_i = 0;
  reg [3:0]  sel_i = 0;
  reg [31:0] dat_i = 0;
  reg [5:0]  test_fail_i = 0;
  reg [2:0]  check_fail_i = 0;
  wire [31:0] dat_o;
  wire ack_o, power_keep_o, clamp_relay_o, relay_chan_a_o, relay_chan_b_o, outputs_en_o;
  wire test_start_o, sys_reset_o, io_diag_en_o, red_led_o, wp_sysdata_o, wp_flash_o, debug_en_o;
  int error_cnt = 0, total_checks = 0, k;
  logic [31:0] eq[$], mq[$], rd;
  logic [3:0] v, e;
  logic [7:0] b0;

  ssm_supply_monitor #(.WD_CYCLES(WD)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .batt_present_i, .ign_above8_i, .term_above8_i, .supply_above10_i, .test_pin_i,
    .test_done_i, .test_fail_i, .overtemp_i, .power_fault_i, .relayed_fault_i, .io_fault_i, .coproc_alive_i,
    .xtal_ok_i, .check_fail_i, .power_keep_o, .clamp_relay_o, .relay_chan_a_o, .relay_chan_b_o,
    .outputs_en_o, .test_start_o, .sys_reset_o, .io_diag_en_o, .red_led_o, .wp_sysdata_o, .wp_flash_o,
    .debug_en_o);

  initial forever #20 clk_i = ~clk_i;

  task automatic bad(input string s);
    error_cnt++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic cmp_pin(input logic g, input logic x, input string s);
    total_checks++;
    if (g !== x) bad(s);
  endtask
  task automatic cmp_bus(input logic [31:0] g, x, m);
    total_checks++;
    if ((g & m) !== (x & m)) bad("read data");
  endtask
  // Monitor takes the oldest note whenever read data comes back
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0 && eq.size() > 0) cmp_bus(dat_o, eq.pop_front(), mq.pop_front());

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    if (!w && m != 0) begin
      eq.push_back(d);
      mq.push_back(m);
    end
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
    if (n >= 20) bad("no ack");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1, a, d, 0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    wb(0, a, x, m);
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 100; i++) begin
      wb(0, `SSM_ADR_STAT, 0, 0);
      if (rd[22:20] === s) return;
    end
    bad("state not reached");
  endtask
  task automatic wait_pulse(input logic srst);
    int i;
    for (i = 0; i < WD + 100 && (srst ? sys_reset_o : test_start_o) !== 1'b1; i++) @(posedge clk_i);
    total_checks++;
    if (i >= WD + 100) bad("pulse missing");
  endtask
  task automatic set_flt(input logic [8:0] f);
    overtemp_i <= f[0];
    power_fault_i <= f[1];
    relayed_fault_i <= f[2];
    io_fault_i <= f[3];
    coproc_alive_i <= !f[4];
    xtal_ok_i <= !f[5];
    check_fail_i <= f[8:6];
  endtask
  task automatic boot(input logic [5:0] f, input logic tp);
    set_flt(0);
    test_pin_i <= tp;
    test_done_i <= 0;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wait_pulse(0);
    test_fail_i <= f;
    test_done_i <= 1;
  endtask
  // Image of n bytes, then a 16-bit sum off by delta
  task automatic ck(input logic [2:0] op, input logic [7:0] base, input int n, input logic [15:0] delta,
                    input logic ok);
    logic [15:0] s;
    s = delta;
    wr(`SSM_ADR_CKCTL, op);
    for (int i = 0; i < n; i++) begin
      s += 8'(base + i * 7);
      wr(`SSM_ADR_CKDAT, 8'(base + i * 7));
    end
    wr(`SSM_ADR_CKDAT, s[15:8]);
    wr(`SSM_ADR_CKDAT, s[7:0]);
    wr(`SSM_ADR_CKCTL, 32'h8);
    rdc(`SSM_ADR_CKCTL, 32'(ok) << 5, 32'h30);
    rdc(`SSM_ADR_CKVAL, 32'(s - delta), 32'hFFFF);
  endtask
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(40 * 60000);
    error_cnt++;
    summarize;
  end

  initial begin
    void'($urandom(32'h19ec));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rdc(`SSM_ADR_CTRL, 0, 32'hF);
    rdc(8'h20, 0, 32'hFFFFFFFF);
    cmp_pin(relay_chan_b_o, 1, "chan b after reset");
    b0 = $urandom;
    ck(1, b0, 12, 0, 1);
    ck(3, b0, 12, 0, 1);
    ck(1, b0 + 1, 12, 1, 0);
    ck(2, b0, 8, 3, 0);
    wr(`SSM_ADR_CKCTL, 2);
    wr(`SSM_ADR_CKDAT, 8'h5A);
    wr(`SSM_ADR_CKCTL, 8);
    rdc(`SSM_ADR_CKCTL, 0, 32'h30);
    ck(2, b0, 8, 0, 1);
    rdc(`SSM_ADR_STAT, 32'h180, 32'h380);
    ck(3, b0 + 2, 12, 0, 0);
    rdc(`SSM_ADR_STAT, 32'h200, 32'h200);
    wr(`SSM_ADR_STAT, 32'h3FF);
    ck(7, b0 + 2, 12, 0, 1);
    rdc(`SSM_ADR_STAT, 0, 32'h200);
    boot(6'h01, 1);
    wait_st(2);
    rdc(`SSM_ADR_STAT, 32'h2, 32'h2);
    cmp_pin(debug_en_o, 1, "debug with test pin");
    cmp_pin(wp_flash_o, 0, "flash open with test pin");
    for (k = 0; k < 6; k++) begin
      boot(6'(1 << k), 0);
      wait_st(4);
      cmp_pin(red_led_o, 1, "fatal red");
      cmp_pin(wp_sysdata_o, 1, "system data protected");
    end
    boot(0, 0);
    wait_st(2);
    cmp_pin(io_diag_en_o, 1, "diag in run");
    repeat (8) begin
      v = 4'($urandom);
      e = v[2] ? v & 4'hD : v;
      wr(`SSM_ADR_WDOG, 0);
      wr(`SSM_ADR_CTRL, 32'(v));
      @(negedge clk_i);
      cmp_pin(relay_chan_a_o, e[1] & e[3], "chan a");
      cmp_pin(relay_chan_b_o, !v[2], "chan b");
      cmp_pin(outputs_en_o, e[1], "outputs");
      cmp_pin(clamp_relay_o, v[0], "clamp");
      rdc(`SSM_ADR_CTRL, 32'(e), 32'hF);
    end
    repeat (3) begin
      repeat (WD - 60) @(posedge clk_i);
      wr(`SSM_ADR_WDOG, 0);
    end
    rdc(`SSM_ADR_STAT, 32'h200000, 32'h700040);
    test_done_i <= 0;
    wait_pulse(1);
    wait_st(1);
    rdc(`SSM_ADR_STAT, 32'h40, 32'h40);
    rdc(`SSM_ADR_CTRL, 0, 32'hF);
    for (k = 0; k < 9; k++) begin
      boot(0, 0);
      wait_st(2);
      set_flt(9'(1 << k));
      wait_st(3);
      cmp_pin(red_led_o, 1, "cyclic red");
      rdc(`SSM_ADR_STAT, 32'(1) << (k < 3 ? k + 2 : 5), 32'(1) << (k < 3 ? k + 2 : 5));
    end
    boot(0, 0);
    wait_st(2);
    wr(`SSM_ADR_CTRL, 1);
    term_above8_i <= 0;
    repeat (10) @(posedge clk_i);
    rdc(`SSM_ADR_STAT, 32'h230000, 32'h730000);
    ign_above8_i <= 0;
    test_done_i <= 0;
    wait_st(5);
    rdc(`SSM_ADR_STAT, 32'h1, 32'h10001);
    cmp_pin(power_keep_o, 1, "latched on battery");
    wr(`SSM_ADR_WDOG, 0);
    wait_pulse(1);
    wait_st(6);
    @(negedge clk_i);
    cmp_pin(power_keep_o, 0, "power released");
    @(posedge clk_i);
    ign_above8_i <= 1;
    repeat (20) @(posedge clk_i);
    rdc(`SSM_ADR_STAT, 32'h600000, 32'h700000);
    term_above8_i <= 1;
    wait_st(1);
    summarize;
  end
endmodule // ssm_supply_monitor_test
